// ### ssar_pkg.sv
// Purpose: Shared constants and state types for the serial SAR readout pair
// Assumes: One 250 MHz clock per end; link pins are asynchronous to it
// Notes:   Times are given in ns and turned into clock cycles here
package ssar_pkg;
   localparam int CLK_FREQ_HZ   = 250_000_000;
   localparam int CLK_PERIOD_NS = 4;

   // Least times round up, longest round down, never below one cycle
   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_floor(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Result format
   localparam int             DATA_BITS = 12;
   localparam logic [DATA_BITS:0] HALF_LSB = 13'h0001;

   // Device side: rising shift-clock edge numbers within one frame
   localparam int         EDGE_W    = 4;
   localparam logic [3:0] MSB_EDGE  = 4'h3;
   localparam logic [3:0] LSB_EDGE  = 4'hE;
   localparam logic [3:0] EDGE_SAT  = 4'hF;

   // Output change delay after a rising shift-clock edge
   localparam int         DOUT_DELAY_NS  = 20;
   localparam int         DOUT_DELAY_CYC = cyc_floor(DOUT_DELAY_NS);
   localparam logic [2:0] DOUT_DELAY     = 3'(DOUT_DELAY_CYC);

   // Synchroniser lanes and their idle levels after reset
   localparam int         IDX_SEL  = 0;
   localparam int         IDX_SCLK = 1;
   localparam int         IDX_PDN  = 2;
   localparam logic [2:0] LINK_RST = 3'h1;

   // Host side timing
   localparam int SCLK_MAX_FAST_HZ  = 6_400_000;
   localparam int SCLK_MAX_LOW_HZ   = 4_800_000;
   localparam int SCLK_HALF_FAST    = (CLK_FREQ_HZ + 2*SCLK_MAX_FAST_HZ - 1) / (2*SCLK_MAX_FAST_HZ);
   localparam int SCLK_HALF_LOW     = (CLK_FREQ_HZ + 2*SCLK_MAX_LOW_HZ - 1) / (2*SCLK_MAX_LOW_HZ);
   localparam int ACQ_FAST_NS       = 468;
   localparam int ACQ_LOW_NS        = 625;
   localparam int SEL_HIGH_NS       = 100;
   localparam int SEL_SETUP_NS      = 35;
   localparam int SEL_SETUP_CYC     = cyc_ceil(SEL_SETUP_NS);
   localparam int WAKE_NS           = 2_000_000;
   localparam int WAKE_CYC_DEF      = cyc_ceil(WAKE_NS);
   localparam int GAP_FAST_CYC      = cyc_ceil((ACQ_FAST_NS > SEL_HIGH_NS) ? ACQ_FAST_NS
                                                                          : SEL_HIGH_NS);
   localparam int TMR_W             = 20;
   localparam logic [4:0] FRAME_EDGES = 5'h10;
   localparam int         BYTE_IDX_W  = 3;
   localparam int         RESULT_LSB  = 1;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_CONV = 2'h1,
      DEV_TAIL = 2'h3,
      DEV_POWER_DOWN_N = 2'h2
   } ssar_dev_state_e;

   typedef enum logic [2:0] {
      HST_WAKE  = 3'h0,
      HST_IDLE  = 3'h1,
      HST_SETUP = 3'h3,
      HST_SHIFT = 3'h2,
      HST_GAP   = 3'h6,
      HST_OFF   = 3'h4
   } ssar_host_state_e;
endpackage

// ### ssar_if.sv
// Purpose: Pins between the converter end and its serial master
// Assumes: Result line has a weak pull-up when floating
// Notes:   The floating level is resolved here so no end sees high impedance
`timescale 1ns/1ps
interface ssar_if;
   logic select_n;
   logic sclk;
   logic power_down_n;
   logic dout;
   logic dout_oe;
   logic dout_seen;

   // Floating line reads as the pull-up level
   assign dout_seen = dout_oe ? dout : 1'b1;

   modport device (
      input  select_n,
      input  sclk,
      input  power_down_n,
      output dout,
      output dout_oe
   );

   modport host (
      output select_n,
      output sclk,
      output power_down_n,
      input  dout_seen
   );
endinterface

// ### ssar_device.sv
// Purpose: Converter end: select-started conversion paced by the shift clock
// Assumes: analog_input_in is the held voltage in half-LSB steps of Vref/4096
// Notes:   All link pins are sampled by clock_in through two flip-flops
//
// Contract
// [RL1] Select falling starts conversion, enters hold
// [RL2] Result line floats while select high
// [RL3] Select falling drives result line low
// [RL4] Output changes only after rising clock, delayed
// [RL5] Two zeros, then MSB on third edge
// [RL6] Remaining bits one per edge; host gives sixteen
// [RL7] Extra edges give zeros, conversion undisturbed
// [RL8] Host keeps shift clock under variant maximum
// [RL9] Bits decided in step, shifted immediately
// [RL10] Host raises select after LSB, waits high time
// [RL11] Power-down low: shutdown, reference off
// [RL12] Host waits reference charge after power-up
// [RL13] Host waits wake-up time after power-down
// [RL14] Straight binary, Vref/4096 steps, midway transitions
// [RL15] Host leaves acquisition time between conversions
// [RL16] Track resumes once conversion finishes
// [RL17] Byte host reads two bytes per result
// [RL18] After abort host waits acquisition time
// [RL19] Select rising clears bit counter
`timescale 1ns/1ps
module ssar_device
   import ssar_pkg::*;
(
   input  wire logic                 clock_in,
   input  wire logic                 srst_in,
   ssar_if.device                    link,
   input  wire logic [DATA_BITS:0]   analog_input_in,
   output logic      [DATA_BITS-1:0] result_out,
   output logic                      result_valid_out,
   output logic                      hold_out,
   output logic                      reference_on_out
);

   // Trial word: current approximation with the bit under test set
   function automatic logic [DATA_BITS-1:0] trial_of(input logic [DATA_BITS-1:0] sar,
                                                     input logic [EDGE_W-1:0]    idx);
      logic [DATA_BITS-1:0] one;
      one = {{(DATA_BITS-1){1'b0}}, 1'b1};
      return sar | (one << idx);
   endfunction

   logic [2:0]           meta_q;
   logic [2:0]           sync_q;
   logic [2:0]           prev_q;
   ssar_dev_state_e      state_q;
   ssar_dev_state_e      state_d;
   logic [EDGE_W-1:0]    edge_q;
   logic [EDGE_W-1:0]    edge_d;
   logic [DATA_BITS:0]   sample_q;
   logic [DATA_BITS-1:0] sar_q;
   logic [DATA_BITS-1:0] sar_d;
   logic [2:0]           dly_q;
   logic                 pend_q;
   logic                 dout_q;
   logic                 oe_q;
   logic [DATA_BITS-1:0] result_q;
   logic                 valid_q;
   logic                 hold_q;
   logic                 ref_q;

   wire [2:0]           link_raw  = {link.power_down_n, link.sclk, link.select_n};
   wire                 pdn       = sync_q[IDX_PDN];
   wire                 sel_fall  = prev_q[IDX_SEL] & ~sync_q[IDX_SEL];
   wire                 sel_rise  = ~prev_q[IDX_SEL] & sync_q[IDX_SEL];
   wire                 sel_high  = sync_q[IDX_SEL];
   wire                 sclk_rise = ~prev_q[IDX_SCLK] & sync_q[IDX_SCLK];
   wire                 in_frame  = (state_q == DEV_CONV) || (state_q == DEV_TAIL);
   wire                 start     = (state_q == DEV_IDLE) && pdn && sel_fall;
   wire                 edge_hit  = in_frame && pdn && sclk_rise && !sel_rise;
   wire [EDGE_W-1:0]    edge_num  = edge_q + 4'h1;
   wire [EDGE_W-1:0]    bit_idx   = LSB_EDGE - edge_num;
   wire [DATA_BITS-1:0] trial     = trial_of(sar_q, bit_idx);
   // Comparator threshold sits half an LSB below the trial code
   wire [DATA_BITS:0]   thresh    = {trial, 1'b0} - HALF_LSB;               // [RL14]
   wire                 decided   = (sample_q >= thresh);
   // Only edges three through fourteen resolve a bit; others shift zeros
   wire                 decide    = edge_hit && (state_q == DEV_CONV)
                                    && (edge_num >= MSB_EDGE);              // [RL5] [RL9]
   wire                 new_bit   = decide & decided;                       // [RL7]
   wire                 last_bit  = decide && (edge_num == LSB_EDGE);       // [RL6]

   // Link pins are asynchronous; only the second stage feeds logic
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         meta_q <= LINK_RST;
         sync_q <= LINK_RST;
         prev_q <= LINK_RST;
      end else begin
         meta_q <= link_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   always_comb begin
      state_d = state_q;
      if (!pdn) begin
         state_d = DEV_POWER_DOWN_N;                                                // [RL11]
      end else begin
         unique case (state_q)
            DEV_POWER_DOWN_N: state_d = DEV_IDLE;
            DEV_IDLE: if (start) begin
               state_d = DEV_CONV;                                          // [RL1]
            end
            DEV_CONV: if (sel_rise) begin
               state_d = DEV_IDLE;
            end else if (last_bit) begin
               state_d = DEV_TAIL;
            end
            DEV_TAIL: if (sel_rise) begin
               state_d = DEV_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      edge_d = edge_q;
      if (!in_frame || sel_rise) begin
         edge_d = '0;                                                       // [RL19]
      end else if (sclk_rise && edge_q != EDGE_SAT) begin
         edge_d = edge_num;
      end
   end

   always_comb begin
      sar_d = sar_q;
      if (start) begin
         sar_d = '0;
      end else if (decide && decided) begin
         sar_d = trial;                                                     // [RL9]
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_q <= DEV_POWER_DOWN_N;
         edge_q  <= '0;
         sar_q   <= '0;
      end else begin
         state_q <= state_d;
         edge_q  <= edge_d;
         sar_q   <= sar_d;
      end
   end

   // Input is frozen at the select falling edge
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sample_q <= '0;
      end else if (start) begin
         sample_q <= analog_input_in;                                       // [RL1]
      end
   end

   // Every shift-clock driven change is delayed; select edges act at once
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         dly_q  <= '0;
         pend_q <= 1'b0;
      end else if (sel_high || !pdn) begin
         dly_q  <= '0;
      end else if (edge_hit) begin
         dly_q  <= DOUT_DELAY;                                              // [RL4]
         pend_q <= new_bit;
      end else if (dly_q != 3'h0) begin
         dly_q  <= dly_q - 3'h1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         oe_q   <= 1'b0;
         dout_q <= 1'b0;
      end else if (sel_high || !pdn) begin
         oe_q   <= 1'b0;                                                    // [RL2]
         dout_q <= 1'b0;
      end else if (start) begin
         oe_q   <= 1'b1;                                                    // [RL3]
         dout_q <= 1'b0;
      end else if (dly_q == 3'h1) begin
         dout_q <= pend_q;                                                  // [RL4]
      end
   end

   // Hold ends with the last decided bit so acquisition starts early
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         hold_q   <= 1'b0;
         ref_q    <= 1'b0;
         result_q <= '0;
         valid_q  <= 1'b0;
      end else begin
         hold_q  <= (state_d == DEV_CONV);                                  // [RL16]
         ref_q   <= pdn;                                                    // [RL11]
         valid_q <= last_bit;
         if (last_bit) begin
            result_q <= sar_d;                                              // [RL14]
         end
      end
   end

   assign link.dout        = dout_q;
   assign link.dout_oe     = oe_q;
   assign result_out       = result_q;
   assign result_valid_out = valid_q;
   assign hold_out         = hold_q;
   assign reference_on_out = ref_q;

endmodule

// ### ssar_host.sv
// Purpose: Serial master end: starts conversions and reads two bytes each
// Assumes: Shift clock is made here by dividing clock_in
// Notes:   Defaults suit the faster variant; raise the half period for the other
`timescale 1ns/1ps
module ssar_host
   import ssar_pkg::*;
#(
   parameter int SCLK_HALF_CYC = SCLK_HALF_FAST,
   parameter int GAP_CYC       = GAP_FAST_CYC,
   parameter int WAKE_CYC      = WAKE_CYC_DEF
) (
   input  wire logic                 clock_in,
   input  wire logic                 srst_in,
   ssar_if.host                      link,
   input  wire logic                 start_in,
   input  wire logic                 shutdown_in,
   output logic      [DATA_BITS-1:0] result_out,
   output logic                      result_valid_out,
   output logic      [7:0]           byte_out,
   output logic                      byte_valid_out,
   output logic                      ready_out
);

   ssar_host_state_e   state_q;
   ssar_host_state_e   state_d;
   logic [TMR_W-1:0]   tmr_q;
   logic [TMR_W-1:0]   tmr_d;
   logic [4:0]         bit_q;
   logic [4:0]         bit_d;
   logic [15:0]        shift_q;
   logic               sclk_q;
   logic               sclk_d;
   logic               sel_q;
   logic               pdn_q;
   logic [1:0]         din_q;
   logic [DATA_BITS-1:0] result_q;
   logic               valid_q;
   logic [7:0]         byte_q;
   logic               bvalid_q;
   logic               ready_q;

   wire        tmr_done = (tmr_q == '0);
   wire        din      = din_q[1];
   wire        rise_now = (state_q == HST_SHIFT) && tmr_done && !sclk_q;
   wire [15:0] shift_n  = {shift_q[14:0], din};
   wire        byte_end = rise_now && (bit_d[BYTE_IDX_W-1:0] == '0);       // [RL17]
   wire        frame_end = (state_q == HST_SHIFT) && tmr_done && sclk_q
                           && (bit_q == FRAME_EDGES);                       // [RL6]

   always_comb begin
      state_d = state_q;
      tmr_d   = tmr_done ? tmr_q : tmr_q - 20'h00001;
      bit_d   = bit_q;
      sclk_d  = sclk_q;
      unique case (state_q)
         HST_WAKE: if (tmr_done) begin
            state_d = HST_IDLE;                                             // [RL12] [RL13]
         end
         HST_IDLE: if (shutdown_in) begin
            state_d = HST_OFF;
         end else if (start_in) begin
            state_d = HST_SETUP;
            tmr_d   = TMR_W'(SEL_SETUP_CYC);
         end
         HST_SETUP: if (tmr_done) begin
            state_d = HST_SHIFT;
            bit_d   = '0;
            tmr_d   = TMR_W'(SCLK_HALF_CYC);
         end
         HST_SHIFT: if (frame_end) begin
            state_d = HST_GAP;                                              // [RL10]
            tmr_d   = TMR_W'(GAP_CYC);                                      // [RL15] [RL18]
            // Clock rests low between frames so each select fall sees it idle
            sclk_d  = 1'b0;                                                 // [RL8]
         end else if (tmr_done) begin
            sclk_d = !sclk_q;                                               // [RL8]
            tmr_d  = TMR_W'(SCLK_HALF_CYC);
            if (!sclk_q) begin
               bit_d = bit_q + 5'h01;
            end
         end
         HST_GAP: if (tmr_done) begin
            state_d = HST_IDLE;
         end
         HST_OFF: if (!shutdown_in) begin
            state_d = HST_WAKE;
            tmr_d   = TMR_W'(WAKE_CYC);                                     // [RL13]
         end
         default: state_d = HST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_q <= HST_WAKE;
         tmr_q   <= TMR_W'(WAKE_CYC);                                       // [RL12]
         bit_q   <= '0;
         sclk_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
         bit_q   <= bit_d;
         sclk_q  <= sclk_d;
      end
   end

   // Result line is sampled as the clock is raised; it changed after the last rise
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         din_q    <= 2'h3;
         shift_q  <= '0;
         sel_q    <= 1'b1;
         pdn_q    <= 1'b1;
         result_q <= '0;
         valid_q  <= 1'b0;
         byte_q   <= '0;
         bvalid_q <= 1'b0;
         ready_q  <= 1'b0;
      end else begin
         din_q    <= {din_q[0], link.dout_seen};
         sel_q    <= !((state_d == HST_SETUP) || (state_d == HST_SHIFT));
         pdn_q    <= (state_d != HST_OFF);
         ready_q  <= (state_d == HST_IDLE);
         valid_q  <= frame_end;
         bvalid_q <= byte_end;
         if (rise_now) begin
            shift_q <= shift_n;
         end
         if (byte_end) begin
            byte_q <= shift_n[7:0];
         end
         if (frame_end) begin
            result_q <= shift_q[RESULT_LSB +: DATA_BITS];                   // [RL17]
         end
      end
   end

   assign link.select_n     = sel_q;
   assign link.sclk         = sclk_q;
   assign link.power_down_n = pdn_q;
   assign result_out        = result_q;
   assign result_valid_out  = valid_q;
   assign byte_out          = byte_q;
   assign byte_valid_out    = bvalid_q;
   assign ready_out         = ready_q;

endmodule

// ### ssar_link_chk.sv
// Purpose: Timing checks on the link between converter end and serial master
// Assumes: One clock domain; link pins are sampled by clock_in
// Notes:   Counters stand in for long repetitions
`timescale 1ns/1ps
module ssar_link_chk
   import ssar_pkg::*;
#(
   parameter int GAP_CYC  = GAP_FAST_CYC,
   parameter int WAKE_CYC = WAKE_CYC_DEF
) (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic power_down_n,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic dout_seen
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   logic [4:0]       rise_q;
   logic [7:0]       hi_q;
   logic [7:0]       run_q;
   logic [TMR_W-1:0] pd_q;

   // Select-high and clock-phase counts start full so a fresh reset never looks like a short gap
   always_ff @(posedge clock_in) begin
      if (srst_in || select_n) rise_q <= 5'h00;
      else if ($rose(sclk)) rise_q <= rise_q + 5'h01;
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) hi_q <= 8'hFF;
      else if (!select_n) hi_q <= 8'h00;
      else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) run_q <= 8'hFF;
      else if ($changed(sclk)) run_q <= 8'h00;
      else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
   end
   always_ff @(posedge clock_in) begin
      if (srst_in || !power_down_n) pd_q <= '0;
      else if (pd_q != '1) pd_q <= pd_q + 1'b1;
   end

   AST_FLOAT_DESELECTED: assert property (select_n [*6] |-> !dout_oe)
      else $error("result line driven while deselected");
   AST_RELEASE_ON_RISE: assert property ($rose(select_n) |-> ##[2:6] !dout_oe)
      else $error("result line not released after select rise");
   AST_DRIVE_LOW_ON_FALL: assert property
      ($fell(select_n) && power_down_n |-> ##[3:6] (dout_oe && !dout))
      else $error("result line not driven low after select fall");
   AST_CHANGE_AFTER_RISE: assert property
      (dout_oe && $past(dout_oe) && $changed(dout) |-> $past(sclk, 7) && !$past(sclk, 10))
      else $error("result bit changed away from a shift clock rise");
   AST_LEAD_ZEROS: assert property ($rose(sclk) && !select_n && rise_q < 5'h03 |-> !dout_seen)
      else $error("leading bit not zero");
   AST_TRAIL_ZEROS: assert property ($rose(sclk) && !select_n && rise_q > 5'h0E |-> !dout_seen)
      else $error("trailing bit not zero");
   AST_SCLK_HALF: assert property ($changed(sclk) |-> run_q >= 8'(SCLK_HALF_FAST - 1))
      else $error("shift clock phase too short");
   AST_SELECT_GAP: assert property ($fell(select_n) |-> hi_q >= 8'(GAP_CYC))
      else $error("select high time too short");
   AST_WAKE_WAIT: assert property ($fell(select_n) |-> pd_q >= TMR_W'(WAKE_CYC - 1))
      else $error("conversion started before wake-up");
   AST_SHUTDOWN_FLOAT: assert property ((!power_down_n) [*6] |-> !dout_oe)
      else $error("result line driven in shutdown");

   COV_START: cover property ($fell(select_n));
   COV_FULL_FRAME: cover property ($rose(select_n) && rise_q == 5'h10);
   COV_WAKE: cover property ($rose(power_down_n));
endmodule

// ### tb_serial_sar_adc_readout.sv
// Purpose: Bench for the converter end facing the serial master end
// Assumes: Second converter end is driven directly to break host rules
// Notes:   Wake time shortened; expectations follow from it
`timescale 1ns/1ps
module tb_serial_sar_adc_readout
   import ssar_pkg::*;
;
   localparam int WAKE_SIM = 50;
   logic                 clock_in = 1'b0;
   logic                 srst_in = 1'b1;
   logic                 start_in = 1'b0;
   logic                 shutdown_in = 1'b0;
   logic [DATA_BITS:0]   analog_q = '0;
   logic [DATA_BITS:0]   analog_b_q = '0;
   logic [DATA_BITS-1:0] dev_result, dev_b_result, host_result;
   logic                 dev_hold, dev_b_hold, dev_ref, dev_b_ref;
   logic                 host_valid, byte_valid, ready;
   logic                 dev_valid, dev_b_valid;
   int                   dev_pulses = 0;
   int                   dev_b_pulses = 0;
   logic [7:0]           byte_val;
   logic [15:0]          word_q = '0;
   logic [15:0]          pair_q = '0;
   logic                 sclk_prev_q = 1'b0;
   logic                 sel_prev_q = 1'b1;
   int                   fails = 0;
   int                   total_checks = 0;
   int                   cycles = 0;

   ssar_if ssar_if_i ();
   ssar_if ssar_if_b_i ();
   ssar_device ssar_device_i (.clock_in(clock_in), .srst_in(srst_in), .link(ssar_if_i),
      .analog_input_in(analog_q), .result_out(dev_result), .result_valid_out(dev_valid),
      .hold_out(dev_hold), .reference_on_out(dev_ref));
   ssar_device ssar_device_b_i (.clock_in(clock_in), .srst_in(srst_in), .link(ssar_if_b_i),
      .analog_input_in(analog_b_q), .result_out(dev_b_result),
      .result_valid_out(dev_b_valid),
      .hold_out(dev_b_hold), .reference_on_out(dev_b_ref));
   ssar_host #(.WAKE_CYC(WAKE_SIM)) ssar_host_i (.clock_in(clock_in), .srst_in(srst_in),
      .link(ssar_if_i), .start_in(start_in), .shutdown_in(shutdown_in),
      .result_out(host_result), .result_valid_out(host_valid), .byte_out(byte_val),
      .byte_valid_out(byte_valid), .ready_out(ready));
   ssar_link_chk #(.GAP_CYC(GAP_FAST_CYC), .WAKE_CYC(WAKE_SIM)) ssar_link_chk_i (
      .clock_in(clock_in), .srst_in(srst_in), .select_n(ssar_if_i.select_n),
      .sclk(ssar_if_i.sclk), .power_down_n(ssar_if_i.power_down_n), .dout(ssar_if_i.dout),
      .dout_oe(ssar_if_i.dout_oe), .dout_seen(ssar_if_i.dout_seen));

   always #2 clock_in = ~clock_in;

   // Wire-level record of each frame, taken where the master samples
   always @(posedge clock_in) begin
      sclk_prev_q <= ssar_if_i.sclk;
      sel_prev_q <= ssar_if_i.select_n;
      if (sel_prev_q && !ssar_if_i.select_n) word_q <= '0;
      else if (!ssar_if_i.select_n && ssar_if_i.sclk && !sclk_prev_q)
         word_q <= {word_q[14:0], ssar_if_i.dout_seen};
      if (byte_valid) pair_q <= {pair_q[7:0], byte_val};
      if (dev_valid) dev_pulses++;
      if (dev_b_valid) dev_b_pulses++;
      cycles++;
      if (cycles > 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
         fails++;
      end
   endtask

   task automatic wait_high(ref logic sig);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < 3000) begin
         @(negedge clock_in);
         n++;
      end
      // A handshake that never comes counts as a mismatch
      if (n >= 3000) check(18'(sig), 18'h1);
   endtask

   // Whole frame through the master end; input in half steps
   task automatic host_frame(input logic [DATA_BITS:0] h);
      logic [11:0] code;
      int          p0;
      code = 12'((h + 13'h0001) >> 1);
      p0 = dev_pulses;
      @(posedge clock_in) analog_q <= h;
      wait_high(ready);
      @(posedge clock_in) start_in <= 1'b1;
      @(posedge clock_in) start_in <= 1'b0;
      repeat (30) @(negedge clock_in);
      check(18'(dev_hold), 18'h1);
      wait_high(host_valid);
      repeat (4) @(negedge clock_in);
      check(18'(host_result), 18'(code));
      check(18'(dev_result), 18'(code));
      check(18'(word_q), 18'({3'h0, code, 1'b0}));
      check(18'(pair_q), 18'({3'h0, code, 1'b0}));
      check(18'(dev_hold), 18'h0);
      check(18'(dev_pulses - p0), 18'h1);
   endtask

   task automatic host_shutdown();
      // Shutdown is only taken in idle, after the select gap
      wait_high(ready);
      @(posedge clock_in) shutdown_in <= 1'b1;
      repeat (20) @(negedge clock_in);
      check(18'(ssar_if_i.power_down_n), 18'h0);
      check(18'(dev_ref), 18'h0);
      check(18'(ssar_if_i.dout_seen), 18'h1);
      @(posedge clock_in) shutdown_in <= 1'b0;
      repeat (20) @(negedge clock_in);
      check(18'(dev_ref), 18'h1);
      host_frame(13'h0AAB);
   endtask

   // Direct frame on the second end; link clock of 80 ns, gap kept long
   task automatic b_frame(input int n, output logic [17:0] w);
      w = '0;
      @(posedge clock_in) ssar_if_b_i.select_n <= 1'b0;
      repeat (12) @(posedge clock_in);
      for (int i = 0; i < n; i++) begin
         @(negedge clock_in) w = {w[16:0], ssar_if_b_i.dout_seen};
         @(posedge clock_in) ssar_if_b_i.sclk <= 1'b1;
         repeat (10) @(posedge clock_in);
         ssar_if_b_i.sclk <= 1'b0;
         repeat (9) @(posedge clock_in);
      end
      @(posedge clock_in) ssar_if_b_i.select_n <= 1'b1;
      repeat (130) @(posedge clock_in);
   endtask

   // Abort after five edges, then an overlong frame
   task automatic b_abort_restart();
      logic [17:0] w;
      int          p0;
      @(posedge clock_in) analog_b_q <= 13'h0AAA;
      p0 = dev_b_pulses;
      check(18'(ssar_if_b_i.dout_seen), 18'h1);
      b_frame(5, w);
      check(w, 18'({3'h0, 2'h1}));
      check(18'(dev_b_pulses - p0), 18'h0);
      b_frame(18, w);
      check(w, {3'h0, 12'h555, 3'h0});
      check(18'(dev_b_result), 18'h555);
      check(18'(dev_b_pulses - p0), 18'h1);
   endtask

   // Select fall while powered down must be ignored
   task automatic b_shutdown_select();
      @(posedge clock_in) ssar_if_b_i.power_down_n <= 1'b0;
      repeat (10) @(posedge clock_in);
      ssar_if_b_i.select_n <= 1'b0;
      repeat (20) @(negedge clock_in);
      check(18'(ssar_if_b_i.dout_seen), 18'h1);
      check(18'(dev_b_hold), 18'h0);
      check(18'(dev_b_ref), 18'h0);
      @(posedge clock_in) ssar_if_b_i.select_n <= 1'b1;
      ssar_if_b_i.power_down_n <= 1'b1;
      repeat (200) @(posedge clock_in);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      logic [DATA_BITS:0] tbl [6];
      tbl = '{13'h0000, 13'h0001, 13'h1554, 13'h0AAB, 13'h0FFF, 13'h1FFE};
      ssar_if_b_i.select_n = 1'b1;
      ssar_if_b_i.sclk = 1'b0;
      ssar_if_b_i.power_down_n = 1'b1;
      repeat (8) @(posedge clock_in);
      srst_in <= 1'b0;
      foreach (tbl[i]) host_frame(tbl[i]);
      host_shutdown();
      repeat (40) @(posedge clock_in);
      b_abort_restart();
      b_shutdown_select();
      end_sim();
   end
endmodule
